// ---- include/ssp_pkg.sv ----
// package of constants and types for the synthesizer serial programming port
// ==========================================================================
package ssp_pkg;
  // ==========================================================
  // word layout
  localparam int WORD_W = 24;
  localparam int ADDR_W = 4;
  localparam int NUM_LATCH = 8;
  localparam int SEL_W = 3;
  localparam int SYNC_STAGES = 2;
  localparam logic [WORD_W-1:0] LATCH_RESET = 24'h000000;
  localparam logic [WORD_W-1:0] QUICK_SETUP_WORD = 24'h20c709;
  localparam logic [ADDR_W-1:0] CODE_L1 = 4'h3;
  localparam logic [ADDR_W-1:0] CODE_L2 = 4'h5;
  localparam logic [ADDR_W-1:0] CODE_L3 = 4'h7;
  localparam logic [ADDR_W-1:0] CODE_L4 = 4'h9;
  localparam logic [ADDR_W-1:0] CODE_L5 = 4'hb;
  localparam logic [ADDR_W-1:0] CODE_L6 = 4'hd;
  localparam logic [ADDR_W-1:0] CODE_L7 = 4'hf;
  localparam logic [SEL_W-1:0] SEL_MAIN = 3'h0;

  // ==========================================================
  // types
  typedef struct packed {
    logic [WORD_W-1:0] rf_integer_fraction_word;
    logic [WORD_W-1:0] rf_ref_denominator_word;
    logic [WORD_W-1:0] aux_divider_powerdown_word;
    logic [WORD_W-1:0] pump_gain_aux_ref_word;
    logic [WORD_W-1:0] fixed_setup_word;
    logic [WORD_W-1:0] extended_fraction_word;
    logic [WORD_W-1:0] fast_acquire_settings_word;
    logic [WORD_W-1:0] counter_reset_control_word;
  } ssp_latches_t;

  typedef struct packed {
    logic serialClk;
    logic serialData;
    logic loadStrobe;
  } ssp_link_t;
endpackage : ssp_pkg

// ---- design/ssp_serial_port.sv ----
// serial shift register and latch bank of the programming port
`timescale 1ns/1ns
`default_nettype none
module ssp_serial_port (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,

  // three-wire link, asynchronous to mclk
  input wire ssp_pkg::ssp_link_t link,

  // latch contents
  output var ssp_pkg::ssp_latches_t latches,

  // load events, one cycle each
  output logic [ssp_pkg::NUM_LATCH-1:0] latchLoad,
  output logic lockCountersReset
);

  // ========================================================
  // local sizes

  // one bit per link pin
  localparam int PIN_W = $bits(ssp_pkg::ssp_link_t);

  // depth of every synchroniser chain
  localparam int SYNC_N = ssp_pkg::SYNC_STAGES;

  // stage whose output is the settled pin level
  localparam int LAST_STAGE = SYNC_N - 1;

  // highest shift bit that survives one more shift
  localparam int KEEP_TOP = ssp_pkg::WORD_W - 2;

  // ========================================================
  // address decode

  // bit 0 low means latch zero whatever bits 3..1 hold, so the
  // main divider word keeps three more payload bits
  function automatic logic [ssp_pkg::SEL_W-1:0] decodeSel(
    input logic [ssp_pkg::ADDR_W-1:0] code
  );
    logic [ssp_pkg::SEL_W-1:0] s;
    s = ssp_pkg::SEL_MAIN;
    if (code[0]) begin
      s = code[ssp_pkg::ADDR_W-1:1];
    end
    return s;
  endfunction : decodeSel

  // one-hot form of a latch index
  function automatic logic [ssp_pkg::NUM_LATCH-1:0] selHot(
    input logic [ssp_pkg::SEL_W-1:0] s
  );
    logic [ssp_pkg::NUM_LATCH-1:0] h;
    h = '0;
    h[s] = 1'b1;
    return h;
  endfunction : selHot

  // ========================================================
  // pin synchronisers

  logic [PIN_W-1:0] pinRaw;

  wire [PIN_W-1:0] pinSync;

  assign pinRaw = link;

  // the first stage feeds only the next one; logic reads the last
  for (genvar b = 0; b < PIN_W; b++) begin : g_sync
    logic [SYNC_N-1:0] chain_ff;
    logic [SYNC_N-1:0] nxt_chain;

    always_comb begin
      nxt_chain = {chain_ff[SYNC_N-2:0], pinRaw[b]};
    end

    always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
        chain_ff <= '0;
      end else begin
        chain_ff <= nxt_chain;
      end
    end

    assign pinSync[b] = chain_ff[LAST_STAGE];
  end : g_sync

  // ========================================================
  // edge detection on settled pins

  wire [PIN_W-1:0] pinRise;

  for (genvar b = 0; b < PIN_W; b++) begin : g_edge
    logic prev_ff;
    logic nxt_prev;

    always_comb begin
      nxt_prev = pinSync[b];
    end

    always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
        // clock and strobe idle low, so release shows no false edge
        prev_ff <= '0;
      end else begin
        prev_ff <= nxt_prev;
      end
    end

    assign pinRise[b] = pinSync[b] & ~prev_ff;
  end : g_edge

  ssp_pkg::ssp_link_t syncLink;

  ssp_pkg::ssp_link_t riseLink;

  logic clkRise;

  logic strobeRise;

  logic sData;

  assign syncLink = pinSync;

  assign riseLink = pinRise;

  assign clkRise = riseLink.serialClk;

  assign strobeRise = riseLink.loadStrobe;

  assign sData = syncLink.serialData;

  // ========================================================
  // input shift register

  logic [ssp_pkg::WORD_W-1:0] shift_ff;

  logic [ssp_pkg::WORD_W-1:0] nxt_shift;

  always_comb begin
    nxt_shift = shift_ff;
    // clock edges while the strobe is high are ignored
    if (clkRise && !syncLink.loadStrobe) begin
      // msb enters first and walks up to bit 23
      nxt_shift = {shift_ff[KEEP_TOP:0], sData};
    end
  end

  // the word is not cleared after a load: a short frame leaves
  // older bits in place, as the host link defines
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      shift_ff <= ssp_pkg::LATCH_RESET;
    end else begin
      shift_ff <= nxt_shift;
    end
  end

  // ========================================================
  // latch selection

  logic [ssp_pkg::SEL_W-1:0] sel;

  logic [ssp_pkg::NUM_LATCH-1:0] hit;

  assign sel = decodeSel(shift_ff[ssp_pkg::ADDR_W-1:0]);

  // exactly one latch takes the word on a strobe rise
  assign hit = strobeRise ? selHot(sel) : '0;

  // ========================================================
  // latch bank

  wire [ssp_pkg::WORD_W-1:0] bank [ssp_pkg::NUM_LATCH];

  for (genvar g = 0; g < ssp_pkg::NUM_LATCH; g++) begin : g_latch
    logic [ssp_pkg::WORD_W-1:0] word_ff;
    logic [ssp_pkg::WORD_W-1:0] nxt_word;

    always_comb begin
      // every other latch keeps its word until its own strobe
      nxt_word = word_ff;
      if (hit[g]) begin
        nxt_word = shift_ff;
      end
    end

    always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
        // latches never written keep this, so a short start-up works
        word_ff <= ssp_pkg::LATCH_RESET;
      end else begin
        word_ff <= nxt_word;
      end
    end

    assign bank[g] = word_ff;
  end : g_latch

  // ========================================================
  // load pulses

  logic [ssp_pkg::NUM_LATCH-1:0] load_ff;

  logic [ssp_pkg::NUM_LATCH-1:0] nxt_load;

  logic lockRst_ff;

  logic nxt_lockRst;

  always_comb begin
    nxt_load = hit;
    // only counters restart; no latch is preset by this
    nxt_lockRst = hit[ssp_pkg::SEL_MAIN];
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      load_ff <= '0;
      lockRst_ff <= '0;
    end else begin
      load_ff <= nxt_load;
      lockRst_ff <= nxt_lockRst;
    end
  end

  // ========================================================
  // outputs

  assign latches.rf_integer_fraction_word = bank[0];

  assign latches.rf_ref_denominator_word = bank[1];

  assign latches.aux_divider_powerdown_word = bank[2];

  assign latches.pump_gain_aux_ref_word = bank[3];

  assign latches.fixed_setup_word = bank[4];

  assign latches.extended_fraction_word = bank[5];

  assign latches.fast_acquire_settings_word = bank[6];

  assign latches.counter_reset_control_word = bank[7];

  assign latchLoad = load_ff;

  assign lockCountersReset = lockRst_ff;

endmodule : ssp_serial_port
`default_nettype wire

// ---- bench/ssp_port_checker.sv ----
// checker of the programming port outputs
`timescale 1ns/1ns
`default_nettype none
module ssp_port_checker (
  input wire logic mclk,
  input wire logic reset,
  input wire ssp_pkg::ssp_link_t link,
  input wire ssp_pkg::ssp_latches_t latches,
  input wire logic [7:0] latchLoad,
  input wire logic lockCountersReset
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  sequence rise; $rose(link.loadStrobe); endsequence
  a_one_hot: assert property ($onehot0(latchLoad)) else $error("dup");
  a_strobe_load: assert property (rise |-> ##[2:5] |latchLoad)
    else $error("no load");
  a_pulse_once: assert property (|latchLoad |=> !latchLoad)
    else $error("long pulse");
  a_load_strobe: assert property (|latchLoad |-> link.loadStrobe)
    else $error("stray load");
  a_lock_pair: assert property (lockCountersReset == latchLoad[0])
    else $error("lock reset");
  a_hold_latches: assert property ($changed(latches)
    |-> |latchLoad || $past(|latchLoad)) else $error("latch moved");
  a_main_code: assert property (latchLoad[0] |-> ##[0:1] !latches[168])
    else $error("main code");
  a_top_code: assert property (latchLoad[7] |-> ##[0:1] &latches[3:0])
    else $error("top code");
endmodule : ssp_port_checker
bind ssp_serial_port ssp_port_checker chk_u (.mclk(mclk), .reset(reset),
  .link(link), .latches(latches), .latchLoad(latchLoad),
  .lockCountersReset(lockCountersReset));
`default_nettype wire

// ---- bench/ssp_host_model.sv ----
// host model of the three-wire link
`timescale 1ns/1ns
`default_nettype none
module ssp_host_model (
  input wire logic mclk,
  output var ssp_pkg::ssp_link_t link = '0
);
  task automatic half(); repeat (20) @(posedge mclk); endtask : half
  // idle data shows the inverse of the last bit, never a stale copy
  task automatic send(input logic [23:0] w);
    for (int i = 23; i >= 0; i--) begin
      // clock falls as the next bit is put out
      link <= '{1'b0, w[i], 1'b0};
      half();
      link.serialClk <= 1'b1;
      half();
    end
    link <= '{1'b0, ~w[0], 1'b0};
    half();
    link.loadStrobe <= 1'b1;
    half();
    link.loadStrobe <= 1'b0;
    half();
  endtask : send
endmodule : ssp_host_model
`default_nettype wire

// ---- bench/tb_synth_serial_program_port.sv ----
// bench of the programming port
`timescale 1ns/1ns
`default_nettype none
module tb_synth_serial_program_port;
  logic mclk = 1'b0, reset = 1'b1;
  ssp_pkg::ssp_link_t link;
  ssp_pkg::ssp_latches_t lat, ex = '0;
  logic [7:0] load;
  logic lockRst;
  int failCount = 0, checks = 0, loadCnt = 0, lockCnt = 0;
  int order[13] = '{1,2,3,4,5,6,7,0,1,2,3,4,0};
  always #2 mclk = ~mclk;
  ssp_host_model host_u (.mclk(mclk), .link(link));
  ssp_serial_port dut_u (.mclk(mclk), .reset(reset), .link(link),
    .latches(lat), .latchLoad(load), .lockCountersReset(lockRst));
  always @(posedge mclk) begin
    if (!reset) begin
      loadCnt += $countones(load);
      lockCnt += int'(lockRst);
    end
  end
  function automatic logic [23:0] mk(int k, logic [23:0] r);
    return k ? {r[23:4], k[2:0], 1'b1} : {r[23:1], 1'b0};
  endfunction : mk
  task automatic cmp(ssp_pkg::ssp_latches_t g, e);
    checks++;
    if (g !== e) $display("wrong value %0t %h %h", $time, g, e);
    failCount += int'(g !== e);
  endtask : cmp
  task automatic cmpN(int g, e);
    checks++;
    if (g != e) $display("wrong value %0t %h %h", $time, g, e);
    failCount += int'(g != e);
  endtask : cmpN
  task automatic summarize();
    $display("fails %0d checks %0d", failCount, checks);
    if (failCount == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  initial begin
    logic [23:0] w;
    void'($urandom(64349));
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    // latch zero goes last, with its upper code bits set to prove the decode
    // second round is a short start-up that leaves latches five to seven alone
    foreach (order[j]) begin
      w = mk(order[j], 24'($urandom) | 24'he);
      if (order[j] == 4) w = ssp_pkg::QUICK_SETUP_WORD;
      host_u.send(w);
      ex[191-24*order[j] -: 24] = w;
      cmp(lat, ex);
    end
    repeat (8) @(posedge mclk);
    cmpN(loadCnt, 13);
    cmpN(lockCnt, 2);
    summarize();
  end
endmodule : tb_synth_serial_program_port
`default_nettype wire
